// ---- verilog/mcarc_pkg.sv ----
// Purpose: Shared constants for the multichannel converter readout control
// Assumes: 10 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package mcarc_pkg;
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned NUM_CH             = 8;
  localparam int unsigned RES_W              = 12;
  localparam logic [7:0]  CFG_RESET          = 8'hFF;
  localparam int unsigned NEXT_RDY_MAX_NS    = 225;
  localparam int unsigned NEXT_RDY_CYC_RAW   = NEXT_RDY_MAX_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned NEXT_RDY_CYC       = (NEXT_RDY_CYC_RAW < 1) ? 1 : NEXT_RDY_CYC_RAW;
  localparam int unsigned EXT_STEP_CLKS      = 3;
  localparam int unsigned EXT_FIRST_CLKS     = 13;
  localparam int unsigned INT_FIRST_NS       = 900;
  localparam int unsigned INT_FIRST_CYC      = INT_FIRST_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [11:0] UNI_ZERO           = 12'h000;
  localparam logic [11:0] UNI_FULL           = 12'hFFF;
  localparam logic [11:0] UNI_MID            = 12'h800;
  localparam logic [11:0] BIP_POS_FULL       = 12'h7FF;
  localparam logic [11:0] BIP_NEG_FULL       = 12'h800;
  localparam int unsigned FIFO_DEPTH         = 8;
  typedef enum logic [1:0] {
    MCARC_IDLE = 2'b00,
    MCARC_WAIT = 2'b01,
    MCARC_PUSH = 2'b10,
    MCARC_DONE = 2'b11
  } mcarc_state_t;
endpackage

// ---- verilog/mcarc_fifo.sv ----
// Purpose: Result FIFO between conversion and the readout bus
// Assumes: Single clock, synchronous active-high reset
// Notes:   Storage in flip-flops; clear empties it for a new sequence
`timescale 1ns/1ps
module mcarc_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  always_ff @(posedge clk) begin
    if (rst || (ce && clr)) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= wp_q + 1'b1;
      end
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- verilog/mcarc_top.sv ----
// Purpose: Sequencing, readout and power control of an eight-channel converter
// Assumes: Host pins sampled by two flops; analog core supplies raw results
// Notes:   Results pass the FIFO into a readout store; reads wrap around
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Internal clock: next ready strobe within 225 ns after bus release; code spaces strobes three clocks (300 ns) apart, not tied to reads.
// RQ2 - External clock: each further ready strobe three conversion clocks after previous.
// RQ3 - Last-result ready goes low once final enabled channel result available.
// RQ4 - After last-result falls, select and read present results in order.
// RQ5 - Read after all results wraps pointer to first result again.
// RQ6 - At power-up every channel is enabled.
// RQ7 - Host waits 1 ms and runs a dummy conversion after power-up.
// RQ8 - Full power-down input high shuts down and overrides channel keep input.
// RQ9 - Shutdown keeps the enable byte; writes still accepted in shutdown.
// RQ10 - In shutdown both ready outputs stay high.
// RQ11 - Data driven whenever select and read low, regardless of shutdown.
// RQ12 - Falling edge of full power-down starts conversion like convert rising edge.
// RQ13 - After shutdown host runs dummy conversion then waits 1 ms.
// RQ14 - Keep input low powers down every channel whose enable bit is clear.
// RQ15 - After enabling new channel host runs dummy conversion, waits 1 ms.
// RQ16 - Keep input high powers every channel unless full shutdown active.
// RQ17 - Unipolar coding is offset binary, 0x000 to 0xFFF, midscale 0x800.
// RQ18 - Bipolar coding is two's complement about midscale.
// RQ19 - Enable bit n controls channel n; set enables, clear disables.
// RQ20 - New enable byte takes effect on next falling convert strobe edge.
// RQ21 - Bipolar full scale 0x7FE to 0x7FF, zero scale 0x800 to 0x801.
// RQ22 - Read pointer returns to first enabled result at each new sequence.
module mcarc_top
  import mcarc_pkg::*;
#(
  parameter int unsigned NCH     = NUM_CH,
  parameter bit          BIPOLAR = 1'b0
) (
  input  wire logic             CLK_SYS,
  input  wire logic             SYS_RST,
  input  wire logic             CE,
  input  wire logic             CS_N,
  input  wire logic             RD_N,
  input  wire logic             WR_N,
  input  wire logic             CONVERT_STROBE,
  input  wire logic             FULL_POWERDOWN,
  input  wire logic             UNSELECTED_CHANNEL_POWER_KEEP,
  input  wire logic             CLOCK_SOURCE_SELECT,
  input  wire logic             CONV_CLK,
  input  wire logic [7:0]       PARALLEL_DATA_LINES_I,
  input  wire logic [RES_W-1:0] RAW_RESULT [NUM_CH],
  output logic      [RES_W-1:0] PARALLEL_DATA_LINES_O,
  output logic                  PARALLEL_DATA_LINES_OE_N,
  output logic                  RESULT_READY_N,
  output logic                  LAST_RESULT_READY_N,
  output logic      [NUM_CH-1:0] CHANNEL_POWER_ON,
  output logic                  ANALOG_POWER_ON
);
  initial begin
    if (NCH < 1 || NCH > NUM_CH) $error("NCH must be 1 to 8");
  end

  // Pin synchronisers, two flops each
  localparam int unsigned NSY = 7;
  logic [NSY-1:0] s1_q;
  logic [NSY-1:0] s2_q;
  logic [NSY-1:0] s3_q;
  logic [7:0]     d1_q;
  logic [7:0]     d2_q;
  wire  [NSY-1:0] pins = {CONV_CLK, CLOCK_SOURCE_SELECT, UNSELECTED_CHANNEL_POWER_KEEP,
                          FULL_POWERDOWN, CONVERT_STROBE, WR_N | CS_N, RD_N | CS_N};
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      // Power-down bit resets low so no false exit edge follows reset
      s1_q <= 7'h77;
      s2_q <= 7'h77;
      s3_q <= 7'h77;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end else if (CE) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= PARALLEL_DATA_LINES_I;
      d2_q <= d1_q;
    end
  end
  wire rd_n_s   = s2_q[0];
  wire wr_n_s   = s2_q[1];
  wire cvt_s    = s2_q[2];
  wire pd_s     = s2_q[3];
  wire keep_s   = s2_q[4];
  wire intclk_s = s2_q[5];
  wire rd_fall  = !s2_q[0] && s3_q[0];
  wire rd_rise  = s2_q[0] && !s3_q[0];
  wire wr_rise  = s2_q[1] && !s3_q[1];
  wire cvt_rise = s2_q[2] && !s3_q[2];
  wire cvt_fall = !s2_q[2] && s3_q[2];
  wire pd_fall  = !s2_q[3] && s3_q[3];
  wire cclk_rise = s2_q[6] && !s3_q[6];

  // Configuration: written byte and byte in effect
  logic [7:0] cfg_wr_q;
  logic [7:0] cfg_act_q;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cfg_wr_q  <= CFG_RESET;                                   // RQ6
      cfg_act_q <= CFG_RESET;                                   // RQ6
    end else if (CE) begin
      if (wr_rise) cfg_wr_q <= d2_q;                            // RQ9
      if (cvt_fall) cfg_act_q <= wr_rise ? d2_q : cfg_wr_q;     // RQ20
    end
  end
  wire [NUM_CH-1:0] ch_mask = (NUM_CH)'((1 << NCH) - 1);
  wire [NUM_CH-1:0] en_ch   = cfg_act_q & ch_mask;              // RQ19

  // Power control
  wire              shut    = pd_s;                             // RQ8
  wire [NUM_CH-1:0] pwr_d   = shut ? 8'h00 :
                              (keep_s ? ch_mask : en_ch);       // RQ14 RQ16

  // Coding of raw offset-binary result
  function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] raw);
    code = BIPOLAR ? (raw ^ UNI_MID) : raw;                     // RQ17 RQ18 RQ21
  endfunction

  // Sequencer
  mcarc_state_t st_q;
  mcarc_state_t st_d;
  logic [10:0]  tmr_q;
  logic [2:0]   ch_q;
  wire          start      = (cvt_rise || pd_fall) && !shut;    // RQ12
  wire          fifo_in_rdy;
  wire          step_ext   = !intclk_s && cclk_rise;
  wire [10:0]   first_cnt  = intclk_s ? 11'(INT_FIRST_CYC) : 11'(EXT_FIRST_CLKS);
  wire [10:0]   next_cnt   = intclk_s ? 11'(NEXT_RDY_CYC) : 11'(EXT_STEP_CLKS);
  // Internal clock runs free, so results never wait on reads
  wire          tick       = intclk_s ? 1'b1 : step_ext;        // RQ1
  wire          tmr_zero   = (tmr_q == 11'h000);
  wire          has_ch     = (en_ch != '0);
  wire [NUM_CH-1:0] above  = en_ch & ~((NUM_CH)'((2 << ch_q) - 1));
  wire          is_last    = (above == '0);
  logic [2:0]   next_ch;
  logic [2:0]   first_ch;
  always_comb begin
    next_ch  = ch_q;
    first_ch = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (above[i]) next_ch = 3'(i);
      if (en_ch[i]) first_ch = 3'(i);
    end
  end
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      MCARC_IDLE: if (start && has_ch) st_d = MCARC_WAIT;
      MCARC_WAIT: if (tmr_zero && tick) st_d = MCARC_PUSH;
      MCARC_PUSH: if (fifo_in_rdy) st_d = is_last ? MCARC_DONE : MCARC_WAIT;
      MCARC_DONE: st_d = MCARC_DONE;
    endcase
    if (shut) st_d = MCARC_IDLE;
    else if (start && has_ch) st_d = MCARC_WAIT;                // RQ12
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_q      <= MCARC_IDLE;
      tmr_q     <= 11'h000;
      ch_q      <= 3'h0;
    end else if (CE) begin
      st_q <= st_d;
      if (start) begin
        tmr_q     <= first_cnt - 11'h001;
        ch_q      <= first_ch;
      end else if (st_q == MCARC_WAIT && tick) begin
        if (!tmr_zero) tmr_q <= tmr_q - 11'h001;
      end else if (st_q == MCARC_PUSH && fifo_in_rdy) begin
        tmr_q     <= next_cnt - 11'h001;                        // RQ1 RQ2
        ch_q      <= next_ch;
      end
    end
  end
  wire push = (st_q == MCARC_PUSH) && !shut && !start;

  // Result FIFO
  wire             fifo_out_vld;
  wire [RES_W+2:0] fifo_out;
  wire             new_seq   = start;
  mcarc_fifo #(.WIDTH(RES_W + 3), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .ce        (CE),
    .clr       (new_seq),
    .in_valid  (push),
    .in_ready  (fifo_in_rdy),
    .in_data   ({is_last, ch_q[1:0] ^ ch_q[1:0], code(RAW_RESULT[ch_q])}),
    .out_valid (fifo_out_vld),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  // Readout store and pointer
  logic [RES_W-1:0] store_q [NUM_CH];
  logic [3:0]       wcnt_q;
  logic [3:0]       rptr_q;
  logic             last_q;
  logic             rdy_n_q;
  wire              pop = fifo_out_vld;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wcnt_q  <= 4'h0;
      last_q  <= 1'b0;
    end else if (CE) begin
      if (new_seq || shut) begin
        wcnt_q <= 4'h0;
        last_q <= 1'b0;
      end else if (pop) begin
        store_q[wcnt_q[2:0]] <= fifo_out[RES_W-1:0];
        wcnt_q               <= wcnt_q + 4'h1;
        if (fifo_out[RES_W+2]) last_q <= 1'b1;                  // RQ3
      end
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rptr_q <= 4'h0;
    end else if (CE) begin
      if (new_seq) rptr_q <= 4'h0;                              // RQ22
      else if (rd_rise && wcnt_q != 4'h0) begin
        if (last_q && rptr_q + 4'h1 >= wcnt_q) rptr_q <= 4'h0;  // RQ5
        else if (rptr_q + 4'h1 < wcnt_q) rptr_q <= rptr_q + 4'h1; // RQ4
      end
    end
  end

  // Ready strobes: one-cycle low pulse per result
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdy_n_q    <= 1'b1;
    end else if (CE) begin
      rdy_n_q    <= !(pop && !shut && !new_seq) ;               // RQ1 RQ2
      if (shut) rdy_n_q <= 1'b1;                                // RQ10
    end
  end

  // Output registers
  wire drive = !rd_n_s;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PARALLEL_DATA_LINES_O    <= 12'h000;
      PARALLEL_DATA_LINES_OE_N <= 1'b1;
      RESULT_READY_N           <= 1'b1;
      LAST_RESULT_READY_N      <= 1'b1;
      CHANNEL_POWER_ON         <= 8'h00;
      ANALOG_POWER_ON          <= 1'b0;
    end else if (CE) begin
      PARALLEL_DATA_LINES_O    <= (wcnt_q != 4'h0) ? store_q[rptr_q[2:0]] : UNI_ZERO;
      PARALLEL_DATA_LINES_OE_N <= !drive;                       // RQ11
      RESULT_READY_N           <= rdy_n_q;
      LAST_RESULT_READY_N      <= !(last_q && !shut);           // RQ3 RQ10
      CHANNEL_POWER_ON         <= pwr_d;                        // RQ14 RQ16
      ANALOG_POWER_ON          <= !shut;                        // RQ8
    end
  end
endmodule

// ---- tb/mcarc_top_chk.sv ----
// Purpose: Port assertions for the converter readout control
// Assumes: CE held high by the bench
// Notes:   Bound into mcarc_top below
`timescale 1ns/1ps
module mcarc_top_chk
  import mcarc_pkg::*;
(
  input wire logic              CLK_SYS,
  input wire logic              SYS_RST,
  input wire logic              CS_N,
  input wire logic              RD_N,
  input wire logic              FULL_POWERDOWN,
  input wire logic              UNSELECTED_CHANNEL_POWER_KEEP,
  input wire logic              CLOCK_SOURCE_SELECT,
  input wire logic [RES_W-1:0]  PARALLEL_DATA_LINES_O,
  input wire logic              PARALLEL_DATA_LINES_OE_N,
  input wire logic              RESULT_READY_N,
  input wire logic              LAST_RESULT_READY_N,
  input wire logic [NUM_CH-1:0] CHANNEL_POWER_ON,
  input wire logic              ANALOG_POWER_ON
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_rst; $fell(SYS_RST) |-> PARALLEL_DATA_LINES_OE_N && RESULT_READY_N && LAST_RESULT_READY_N; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_oe_on; (!CS_N && !RD_N)[*5] |-> !PARALLEL_DATA_LINES_OE_N; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data lines not driven");
  property p_oe_off; (CS_N || RD_N)[*5] |-> PARALLEL_DATA_LINES_OE_N; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data lines driven without read");
  property p_full_powerdown_rdy; FULL_POWERDOWN[*5] |-> RESULT_READY_N && LAST_RESULT_READY_N; endproperty
  a_full_powerdown_rdy: assert property (p_full_powerdown_rdy) else $error("ready low in shutdown");
  property p_full_powerdown_pwr; FULL_POWERDOWN[*5] |-> !ANALOG_POWER_ON && CHANNEL_POWER_ON == '0; endproperty
  a_full_powerdown_pwr: assert property (p_full_powerdown_pwr) else $error("powered in shutdown");
  property p_keep; (!FULL_POWERDOWN && UNSELECTED_CHANNEL_POWER_KEEP)[*5] |-> ANALOG_POWER_ON && &CHANNEL_POWER_ON;
  endproperty
  a_keep: assert property (p_keep) else $error("channel unpowered with keep high");
  property p_pulse; $fell(RESULT_READY_N) |=> RESULT_READY_N; endproperty
  a_pulse: assert property (p_pulse) else $error("ready strobe too long");
  property p_pd_start; $fell(FULL_POWERDOWN) && CLOCK_SOURCE_SELECT |-> ##[1:1000] !LAST_RESULT_READY_N; endproperty
  a_pd_start: assert property (p_pd_start) else $error("no conversion after shutdown exit");
  property p_hold; (!CS_N && !RD_N)[*6] |=> $stable(PARALLEL_DATA_LINES_O); endproperty
  a_hold: assert property (p_hold) else $error("result changed within read");
endmodule
bind mcarc_top mcarc_top_chk u_chk (.CLK_SYS, .SYS_RST, .CS_N, .RD_N, .FULL_POWERDOWN,
  .UNSELECTED_CHANNEL_POWER_KEEP, .CLOCK_SOURCE_SELECT, .PARALLEL_DATA_LINES_O, .PARALLEL_DATA_LINES_OE_N,
  .RESULT_READY_N, .LAST_RESULT_READY_N, .CHANNEL_POWER_ON, .ANALOG_POWER_ON);

// ---- tb/mcarc_host.sv ----
// Purpose: Host processor model on the parallel bus
// Assumes: Strobes change at the falling clock edge
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module mcarc_host (
  input  wire logic clk,
  input  wire logic last_n,
  output logic      cs_n,
  output logic      rd_n,
  output logic      wr_n,
  output logic      conv,
  output logic [7:0] d
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    conv = 1'b1;
    d = 8'h00;
  end
  task automatic wr(input logic [7:0] v);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    d = v;
    repeat (5) @(negedge clk);
    wr_n = 1'b1;
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    d = ~v;
  endtask
  task automatic cnv();
    @(negedge clk);
    conv = 1'b0;
    repeat (5) @(negedge clk);
    conv = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  // Bounded wait for the last result before any read
  task automatic wait_last();
    for (int i = 0; i < 3000 && last_n !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic rd();
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (6) @(negedge clk);
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic dummy();
    cnv();
    wait_last();
  endtask
  task automatic wake();
    repeat (10000) @(negedge clk);
  endtask
endmodule

// ---- tb/mcarc_top_tb.sv ----
// Purpose: Self-checking bench for the converter readout control
// Assumes: Unipolar build, 10 MHz clock
// Notes:   Read results are compared against a queue of expectations
`timescale 1ns/1ps
module mcarc_top_tb
  import mcarc_pkg::*;
;
  logic clk, rst, fpd, keep, csel, cclk, oe_n, rdy_n, last_n, apwr;
  logic [RES_W-1:0]  raw [NUM_CH];
  logic [RES_W-1:0]  dout;
  logic [NUM_CH-1:0] cpwr;
  logic [RES_W-1:0]  exp_q [$];
  logic cs_n, rd_n, wr_n, conv;
  logic [7:0] hd;
  wire  [7:0] din = oe_n ? hd : dout[7:0];
  int num_errors, n_checks, cyc;
  mcarc_host h (.clk(clk), .last_n(last_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .conv(conv), .d(hd));
  mcarc_top #(.NCH(NUM_CH), .BIPOLAR(1'b0)) dut (.CLK_SYS(clk), .SYS_RST(rst), .CE(1'b1), .CS_N(cs_n),
    .RD_N(rd_n), .WR_N(wr_n), .CONVERT_STROBE(conv), .FULL_POWERDOWN(fpd), .UNSELECTED_CHANNEL_POWER_KEEP(keep),
    .CLOCK_SOURCE_SELECT(csel), .CONV_CLK(cclk), .PARALLEL_DATA_LINES_I(din), .RAW_RESULT(raw),
    .PARALLEL_DATA_LINES_O(dout), .PARALLEL_DATA_LINES_OE_N(oe_n), .RESULT_READY_N(rdy_n),
    .LAST_RESULT_READY_N(last_n), .CHANNEL_POWER_ON(cpwr), .ANALOG_POWER_ON(apwr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    cclk = 1'b0;
    forever #237 cclk = ~cclk;
  end
  task automatic chk(input string nm, input logic [RES_W-1:0] e, input logic [RES_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge rd_n) if (exp_q.size() > 0) chk("result", exp_q.pop_front(), dout);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      final_report();
    end
  end
  // One sequence: convert, read every enabled result, then one wrapped read
  task automatic run_seq(input logic [7:0] cfg);
    int f;
    f = -1;
    @(negedge clk);
    for (int i = 0; i < NUM_CH; i++) raw[i] = RES_W'($urandom);
    raw[0] = UNI_ZERO;
    raw[1] = UNI_MID;
    raw[NUM_CH-1] = UNI_FULL;
    h.dummy();
    chk("last_ready", '0, RES_W'(last_n));
    for (int i = 0; i < NUM_CH; i++) if (cfg[i]) begin
      if (f < 0) f = i;
      exp_q.push_back(raw[i]);
      h.rd();
    end
    exp_q.push_back(raw[f]);
    h.rd();
  endtask
  initial begin
    rst = 1'b1;
    fpd = 1'b0;
    keep = 1'b1;
    csel = 1'b1;
    raw = '{default: 12'h000};
    void'($urandom(32'h03F4));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("idle_out", 12'h007, {9'h000, oe_n, rdy_n, last_n});
    h.wake();
    h.dummy();
    run_seq(8'hFF);
    h.wr(8'h81);
    run_seq(8'h81);
    keep = 1'b0;
    repeat (6) @(negedge clk);
    chk("ch_power", 12'h081, RES_W'(cpwr));
    fpd = 1'b1;
    repeat (6) @(negedge clk);
    chk("full_powerdown_out", 12'h003, {10'h000, rdy_n, last_n});
    chk("full_powerdown_power", 12'h000, {3'h0, apwr, cpwr});
    h.wr(8'h3C);
    fork
      h.rd();
      begin
        repeat (5) @(negedge clk);
        chk("oe_n_full_powerdown", '0, RES_W'(oe_n));
      end
    join
    fpd = 1'b0;
    h.wait_last();
    chk("pd_exit_last", '0, RES_W'(last_n));
    h.wake();
    h.dummy();
    h.wake();
    chk("ch_power_new", 12'h03C, RES_W'(cpwr));
    run_seq(8'h3C);
    csel = 1'b0;
    keep = 1'b1;
    run_seq(8'h3C);
    final_report();
  end
endmodule
